// file: src/angle_spi_pkg.sv
/*
 * shared constants for the angle sensor serial port: frame layout,
 * command codes, configuration register indices and timing counts.
 * assumes a 40 MHz ref_clk.
 */
package angle_spi_pkg;
    // clock and front end rate
    localparam int CLK_HZ     = 40_000_000;
    localparam int SAMPLE_HZ  = 1_000_000;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    // serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_MSB    = 15;
    localparam int CMD_LSB    = 13;
    localparam int ADDR_MSB   = 12;
    localparam int ADDR_LSB   = 8;
    localparam int DATA_MSB   = 7;
    localparam logic [2:0] CMD_READ  = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    // configuration registers
    localparam int REG_COUNT = 32;
    localparam logic [4:0] REG_ZERO_LO = 5'h00;
    localparam logic [4:0] REG_ZERO_HI = 5'h01;
    localparam logic [4:0] REG_DIR     = 5'h09;
    localparam int         DIR_BIT     = 7;
    localparam logic [4:0] REG_FILT    = 5'h0E;
    localparam logic [7:0] FILT_RESET  = 8'h04;
    localparam logic [7:0] CFG_RESET   = 8'h00;
    // non-volatile write wait
    localparam int NVM_WAIT_MS  = 20;
    localparam int NVM_WAIT_CYC = (CLK_HZ / 1000) * NVM_WAIT_MS;
    // filter fixed point
    localparam int FRAC_BITS = 16;
    // what the next frame returns
    typedef enum logic {RESP_ANGLE, RESP_REG} resp_t;
endpackage

// file: src/angle_frontend.sv
/*
 * front end sampler: catches the converter's phase word and issues one
 * angle sample per microsecond.
 * assumes the phase word is asynchronous to ref_clk and slow-moving.
 */
`timescale 1ns/10ps
`default_nettype none
module angle_frontend
    import angle_spi_pkg::*;
#(
    parameter int PERIOD = SAMPLE_CYC
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // converter phase word
    input  wire logic [15:0] tdcPhase,
    // sample stream
    output logic      [15:0] sampleWord,
    output logic             sampleValid
);
    logic [15:0] phaseS1_r;  // first sync stage
    logic [15:0] phaseS2_r;  // second sync stage
    logic [7:0]  divCnt_r;   // rate divider

    // two flops; a torn word only lasts one sample and the filter eats it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phaseS1_r <= 16'h0000;
            phaseS2_r <= 16'h0000;
        end else begin
            phaseS1_r <= tdcPhase;
            phaseS2_r <= phaseS1_r;
        end
    end

    // one sample every PERIOD cycles
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            divCnt_r    <= 8'h00;
            sampleValid <= 1'b0;
            sampleWord  <= 16'h0000;
        end else if (divCnt_r == 8'(PERIOD - 1)) begin
            divCnt_r    <= 8'h00;
            sampleValid <= 1'b1;
            sampleWord  <= phaseS2_r;
        end else begin
            divCnt_r    <= divCnt_r + 8'h01;
            sampleValid <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_sample_rate;
        sampleValid |=> !sampleValid [*8];
    endproperty
    a_sample_rate: assert property (p_sample_rate)
        else $error("angle samples come too fast");
endmodule // angle_frontend
`default_nettype wire

// file: src/angle_filter.sv
/*
 * second order tracking filter (1+2ts)/(1+ts)^2 on a wrapping angle.
 * assumes one input sample per update; time constant is 2^k samples.
 */
`timescale 1ns/10ps
`default_nettype none
module angle_filter
    import angle_spi_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // input stream and time constant exponent (1..7)
    input  wire logic [15:0] sampleWord,
    input  wire logic        sampleValid,
    input  wire logic [2:0]  tauShift,
    // smoothed angle
    output logic      [15:0] filtWord
);
    logic signed [31:0] pos_r;  // position, 16.16
    logic signed [31:0] vel_r;  // velocity term
    logic signed [15:0] err;    // wrapped error
    logic signed [31:0] errF;   // error in fixed point
    logic [2:0]         k;      // clamped exponent

    // wrapping subtraction keeps the loop correct across 0/360
    always_comb begin
        k    = (tauShift == 3'h0) ? 3'h1 : tauShift;
        err  = $signed(sampleWord - pos_r[31:16]);
        errF = {err, 16'h0000};
    end

    // the integrator term gives zero lag at constant speed
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pos_r <= 32'sh0;
            vel_r <= 32'sh0;
        end else if (sampleValid) begin
            pos_r <= pos_r + vel_r + (errF >>> (k - 3'h1));
            vel_r <= vel_r + (errF >>> {k, 1'b0});
        end
    end

    assign filtWord = pos_r[31:16];
endmodule // angle_filter
`default_nettype wire

// file: src/angle_sensor_spi_port.sv
/*
 * serial slave port of the angle sensor: front end, smoothing filter,
 * configuration store with slow non-volatile writes, and the link
 * itself with automatic clock mode detection.
 * assumes the link pins are asynchronous and the link clock is at
 * most a quarter of ref_clk so every edge is seen after sampling.
 */
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - link works in clock mode 0 and 3
// - capture on rising, change on falling
// - mode found from clock idle level
// - 20 ms wait after write; early gives old
// - angle read, register read, register write
// - new angle word about every microsecond
// - smoothing filter (1+2ts)/(1+ts)^2
// - angle grows clockwise by default
// - direction and zero reference configurable
// - two-wire path delivers angle only
// - select falling freezes, rising releases buffer
// - 16 clocks, MSB first, zero padded
// - read request 010, address, then value
// - write request 100, address, data, echo
module angle_sensor_spi_port
    import angle_spi_pkg::*;
#(
    parameter int NVM_WAIT   = NVM_WAIT_CYC,  // cycles of write wait
    parameter int ANGLE_BITS = 16             // useful angle bits
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // serial link pins
    input  wire logic        sclkPin,
    input  wire logic        selectN,
    input  wire logic        mosiPin,
    output logic             misoOut,
    output logic             misoOe,
    // converter phase word
    input  wire logic [15:0] tdcPhase,
    // frozen angle for the two-wire path
    output logic      [15:0] angleWord,
    // non-volatile write in progress
    output logic             nvmBusy
);
    // resolution mask: unused low bits read as zero
    localparam logic [15:0] RES_MASK =
        16'(~((17'h1 << (16 - ANGLE_BITS)) - 17'h1));

    logic        sclkS1_r;  // sync stage 1, read only by stage 2
    logic        sclkS2_r;  // synced link clock
    logic        sclkD_r;   // delayed for edges
    logic        selS1_r;   // sync stage 1
    logic        selS2_r;   // synced select, low active
    logic        selD_r;    // delayed for edges
    logic        mosiS1_r;  // sync stage 1
    logic        mosiS2_r;  // synced data in
    logic        sclkRise;  // capture edge
    logic        sclkFall;  // launch edge
    logic        frameStart;
    logic        frameEnd;
    logic        active;    // select asserted

    logic [4:0]  bitCnt_r;  // rising edges in frame
    logic [15:0] rxShift_r; // received word
    logic [15:0] txShift_r; // outgoing word
    logic        skipFall_r;// mode 3: first fall only launches
    resp_t       respKind_r;// what the next frame returns
    logic [4:0]  respAddr_r;// register for the next frame

    logic [7:0]  cfgMem_r [REG_COUNT]; // configuration store
    logic [22:0] nvmCnt_r;  // write wait counter
    logic [4:0]  pendAddr_r;// write target
    logic [7:0]  pendData_r;// write value

    logic [15:0] sampleWord;
    logic        sampleValid;
    logic [15:0] filtWord;
    logic [15:0] zeroRef;   // zero angle reference
    logic [15:0] relAngle;  // filtered minus zero
    logic [15:0] outAngle;  // direction applied, masked
    logic [15:0] loadWord;  // word loaded at frame start
    logic [2:0]  rxCmd;
    logic [4:0]  rxAddr;

    // one sample per microsecond from the converter
    angle_frontend u_frontend (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .tdcPhase   (tdcPhase),
        .sampleWord (sampleWord),
        .sampleValid(sampleValid)
    );

    // smoothing with a configurable time constant
    angle_filter u_filter (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .sampleWord (sampleWord),
        .sampleValid(sampleValid),
        .tauShift   (cfgMem_r[REG_FILT][2:0]),
        .filtWord   (filtWord)
    );

    // pin synchronisers; edges come from stage 2 and its delay
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sclkS1_r <= 1'b0;
            sclkS2_r <= 1'b0;
            sclkD_r  <= 1'b0;
            selS1_r  <= 1'b1;
            selS2_r  <= 1'b1;
            selD_r   <= 1'b1;
            mosiS1_r <= 1'b0;
            mosiS2_r <= 1'b0;
        end else begin
            sclkS1_r <= sclkPin;
            sclkS2_r <= sclkS1_r;
            sclkD_r  <= sclkS2_r;
            selS1_r  <= selectN;
            selS2_r  <= selS1_r;
            selD_r   <= selS2_r;
            mosiS1_r <= mosiPin;
            mosiS2_r <= mosiS1_r;
        end
    end

    // edge and frame events
    always_comb begin
        sclkRise   = sclkS2_r & ~sclkD_r;
        sclkFall   = ~sclkS2_r & sclkD_r;
        frameStart = selD_r & ~selS2_r;
        frameEnd   = ~selD_r & selS2_r;
        active     = ~selS2_r;
        rxCmd      = rxShift_r[CMD_MSB:CMD_LSB];
        rxAddr     = rxShift_r[ADDR_MSB:ADDR_LSB];
    end

    // zero reference and direction applied to the filtered angle
    always_comb begin
        zeroRef  = {cfgMem_r[REG_ZERO_HI], cfgMem_r[REG_ZERO_LO]};
        relAngle = filtWord - zeroRef;
        // direction bit clear means clockwise counts up
        if (cfgMem_r[REG_DIR][DIR_BIT]) begin
            outAngle = (16'h0000 - relAngle) & RES_MASK;
        end else begin
            outAngle = relAngle & RES_MASK;
        end
        // register answers sit in the top byte, rest zeros
        if (respKind_r == RESP_REG) begin
            loadWord = {cfgMem_r[respAddr_r], 8'h00};
        end else begin
            loadWord = angleWord;
        end
    end

    // output buffer refreshes only while select is released;
    // the two-wire path reads this word and has no register access
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            angleWord <= 16'h0000;
        end else if (sampleValid && !active) begin
            angleWord <= outAngle;
        end
    end

    // receive side: bits taken on the rising edge in either mode;
    // no timeout anywhere, a stopped clock just holds the frame
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bitCnt_r  <= 5'h00;
            rxShift_r <= 16'h0000;
        end else if (frameStart) begin
            bitCnt_r  <= 5'h00;
        end else if (active && sclkRise) begin
            rxShift_r <= {rxShift_r[14:0], mosiS2_r};
            if (bitCnt_r != 5'h1F) begin
                bitCnt_r <= bitCnt_r + 5'h01;
            end
        end
    end

    // transmit side: msb is out at select fall; in mode 3 the first
    // fall is the launch of that msb, so it must not shift
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            txShift_r  <= 16'h0000;
            misoOut    <= 1'b0;
            skipFall_r <= 1'b0;
        end else if (frameStart) begin
            txShift_r  <= loadWord;
            misoOut    <= loadWord[15];
            skipFall_r <= sclkS2_r;
        end else if (active && sclkFall) begin
            if (skipFall_r) begin
                skipFall_r <= 1'b0;
            end else begin
                txShift_r <= {txShift_r[14:0], 1'b0};
                misoOut   <= txShift_r[14];
            end
        end
    end

    // the data pin is driven only inside a frame
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            misoOe <= 1'b0;
        end else begin
            misoOe <= active;
        end
    end

    // command decode at select rise; partial frames are angle reads
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            respKind_r <= RESP_ANGLE;
            respAddr_r <= 5'h00;
        end else if (frameEnd) begin
            respKind_r <= RESP_ANGLE;
            if (bitCnt_r == 5'(FRAME_BITS)) begin
                unique case (rxCmd)
                    CMD_READ: begin
                        respKind_r <= RESP_REG;
                        respAddr_r <= rxAddr;
                    end
                    CMD_WRITE: begin
                        respKind_r <= RESP_REG;
                        respAddr_r <= rxAddr;
                    end
                    default: begin
                        respKind_r <= RESP_ANGLE;
                    end
                endcase
            end
        end
    end

    // slow store: value lands only after the full wait, so an early
    // readout still shows the old contents
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            nvmBusy    <= 1'b0;
            nvmCnt_r   <= 23'h000000;
            pendAddr_r <= 5'h00;
            pendData_r <= 8'h00;
            for (int i = 0; i < REG_COUNT; i++) begin
                cfgMem_r[i] <= CFG_RESET;
            end
            cfgMem_r[REG_FILT] <= FILT_RESET;
        end else if (nvmBusy) begin
            if (nvmCnt_r == 23'h000001) begin
                nvmBusy              <= 1'b0;
                cfgMem_r[pendAddr_r] <= pendData_r;
            end
            nvmCnt_r <= nvmCnt_r - 23'h000001;
        end else if (frameEnd && bitCnt_r == 5'(FRAME_BITS)
                     && rxCmd == CMD_WRITE) begin
            // a write landing while one is pending is dropped
            nvmBusy    <= 1'b1;
            nvmCnt_r   <= 23'(NVM_WAIT);
            pendAddr_r <= rxAddr;
            pendData_r <= rxShift_r[DATA_MSB:0];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_oe_in_frame;
        frameStart |=> misoOe && misoOut == $past(loadWord[15]);
    endproperty
    a_oe_in_frame: assert property (p_oe_in_frame)
        else $error("frame start did not drive msb");

    property p_mode3_hold;
        active && sclkFall && skipFall_r && !frameStart
            |=> $stable(misoOut);
    endproperty
    a_mode3_hold: assert property (p_mode3_hold)
        else $error("mode 3 launch edge shifted data");

    property p_shift_fall;
        active && sclkFall && !skipFall_r && !frameStart
            |=> misoOut == $past(txShift_r[14]);
    endproperty
    a_shift_fall: assert property (p_shift_fall)
        else $error("data did not advance on falling edge");

    property p_stable_rise;
        active && sclkRise && !frameStart |=> $stable(misoOut);
    endproperty
    a_stable_rise: assert property (p_stable_rise)
        else $error("data changed on rising edge");

    property p_freeze;
        active && $past(active) |-> $stable(angleWord);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("output buffer moved inside a frame");

    property p_read_resp;
        frameEnd && bitCnt_r == 5'h10 && rxCmd == CMD_READ
            |=> respKind_r == RESP_REG && respAddr_r == $past(rxAddr);
    endproperty
    a_read_resp: assert property (p_read_resp)
        else $error("read request not answered with register");

    property p_short_frame;
        frameEnd && bitCnt_r != 5'h10 |=> respKind_r == RESP_ANGLE;
    endproperty
    a_short_frame: assert property (p_short_frame)
        else $error("partial frame taken as command");

    property p_nvm_commit;
        nvmBusy && nvmCnt_r == 23'h000001
            |=> !nvmBusy && cfgMem_r[$past(pendAddr_r)] ==
                $past(pendData_r);
    endproperty
    a_nvm_commit: assert property (p_nvm_commit)
        else $error("write not stored at end of wait");

    c_read: cover property (frameEnd && rxCmd == CMD_READ);
    c_write: cover property (frameEnd && rxCmd == CMD_WRITE);
    c_mode3: cover property (frameStart && sclkS2_r);
endmodule // angle_sensor_spi_port
`default_nettype wire

// file: verification/spi_master_model.sv
/*
 * master side model of the angle port link: drives select, clock and
 * command bits, samples the reply bit by bit.
 * assumes the caller starts each frame on a ref_clk falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
    // link pins towards the port
    output var logic sclkPin,
    output var logic selectN,
    output var logic mosiPin,
    // reply pin and its enable
    input  wire logic misoOut,
    input  wire logic misoOe
);
    logic lastBit; // last level seen on the reply wire

    // idle link at time zero
    initial begin
        sclkPin = 1'b0;
        selectN = 1'b1;
        mosiPin = 1'b0;
        lastBit = 1'b0;
    end

    // one 16 bit frame, 200 ns clock, below the 10 MHz limit
    // nBits below 16 gives a cut frame, top bits of the reply only
    task automatic frame(input logic mode3, input logic [15:0] tx,
                         input int nBits, output logic [15:0] rx);
        sclkPin = mode3; // idle level chooses the mode
        #100;
        selectN = 1'b0;
        #100; // select to first edge above 80 ns
        for (int i = 15; i >= 16 - nBits; i--) begin // msb first
            if (mode3) sclkPin = 1'b0;
            mosiPin = tx[i]; // change on falling
            #100;
            sclkPin = 1'b1;
            // undriven wire shows the inverse, a stale bit never passes
            rx[i] = misoOe ? misoOut : ~lastBit; // capture on rising
            lastBit = rx[i];
            #100;
            if (!mode3) sclkPin = 1'b0;
        end
        #100;
        selectN = 1'b1;
        mosiPin = ~mosiPin; // released: no stale level
        #800; // idle over 750 ns around every frame
    endtask
endmodule // spi_master_model
`default_nettype wire

// file: verification/angle_sensor_spi_port_tb_top.sv
/*
 * bench for the angle sensor serial port: master model on the link,
 * random phase words and modes, register and angle readouts.
 * assumes a 40 MHz ref_clk; store wait and angle width are shortened.
 */
`timescale 1ns/10ps
`default_nettype none
module angle_sensor_spi_port_tb_top
    import angle_spi_pkg::*;
;
    localparam int          WAIT_CYC = 400;      // short store wait
    localparam int          USE_BITS = 12;       // low nibble padded
    localparam logic [15:0] PAD      = 16'hFFF0; // useful angle bits
    logic        ref_clk;      // 40 MHz
    logic        nrst;         // sync reset, low active
    logic        sclkPin;      // link clock from the model
    logic        selectN;      // frame select
    logic        mosiPin;      // command bits
    logic        misoOut;      // reply bits
    logic        misoOe;       // reply enable
    logic [15:0] tdcPhase;     // converter word
    logic [15:0] angleWord;    // frozen angle
    logic        nvmBusy;      // store wait pending
    int          num_errors;   // mismatches
    int          total_checks; // comparisons
    int          busyCnt;      // cycles seen busy
    logic [15:0] r;            // last reply
    logic [15:0] ph;           // phase under test
    logic [15:0] z;            // zero reference
    logic [4:0]  a;            // register index
    logic [7:0]  d;            // register value
    logic [4:0]  tbl [5];      // registers for the reset reads

    angle_sensor_spi_port #(.NVM_WAIT(WAIT_CYC), .ANGLE_BITS(USE_BITS))
        angle_sensor_spi_port_i (.ref_clk(ref_clk), .nrst(nrst),
        .sclkPin(sclkPin), .selectN(selectN), .mosiPin(mosiPin),
        .misoOut(misoOut), .misoOe(misoOe), .tdcPhase(tdcPhase),
        .angleWord(angleWord), .nvmBusy(nvmBusy));
    spi_master_model spi_master_model_i (.sclkPin(sclkPin),
        .selectN(selectN), .mosiPin(mosiPin), .misoOut(misoOut),
        .misoOe(misoOe));

    // 25 ns clock
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    // length of the store wait since reset; one driver only
    always @(posedge ref_clk)
        if (!nrst) busyCnt <= 0;
        else if (nvmBusy === 1'b1) busyCnt <= busyCnt + 1;

    task automatic chk16(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // filtered values may sit a few steps off
    task automatic chkNear(input string n, input logic [15:0] e,
                           input logic [15:0] g, input int tol);
        logic signed [15:0] df;
        df = g - e;
        total_checks++;
        if ((^g === 1'bx) || df > tol || df < -tol) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // one frame in a random clock mode
    task automatic xfer(input logic [15:0] tx);
        spi_master_model_i.frame(1'($urandom % 2), tx, 16, r);
    endtask

    function automatic logic [15:0] cfgReply(input logic [4:0] ad);
        return {(ad == REG_FILT) ? FILT_RESET : CFG_RESET, 8'h00};
    endfunction

    // bounded wait for the store to finish
    task automatic waitStore();
        for (int i = 0; i < 4 * WAIT_CYC && nvmBusy !== 1'b0; i++)
            @(negedge ref_clk);
        chk16("store busy", 16'h0, {15'h0, nvmBusy});
    endtask

    task automatic wr(input logic [4:0] ad, input logic [7:0] v);
        xfer({CMD_WRITE, ad, v});
        waitStore();
    endtask

    // settle, then check port and frame against the expected angle
    task automatic angChk(input logic [15:0] e);
        repeat (4000) @(negedge ref_clk);
        chkNear("angle port", e & PAD, angleWord, 16);
        xfer(16'h0000);
        xfer(16'h0000);
        chkNear("angle frame", e & PAD, r, 16);
        chk16("pad bits", 16'h0, r & ~PAD);
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // watchdog, far beyond the expected run
    initial begin
        #1_500_000;
        num_errors++;
        wrap_up();
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        tdcPhase = 16'h0000;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(32'h1034));
        repeat (16) @(negedge ref_clk);
        chk16("reset flags", 16'h0, {13'h0, misoOe, misoOut, nvmBusy});
        chk16("reset angle", 16'h0, angleWord);
        nrst = 1'b1;
        repeat (8) @(negedge ref_clk);
        // reset values, back to back reads
        tbl = '{REG_FILT, REG_DIR, REG_ZERO_LO, REG_ZERO_HI, 5'h10};
        tbl[4] = 5'h10 | 5'($urandom % 16);
        xfer({CMD_READ, tbl[0], 8'h00});
        for (int i = 1; i <= 5; i++) begin
            xfer({CMD_READ, tbl[i % 5], 8'h00});
            chk16("reset reg", cfgReply(tbl[i - 1]), r);
        end
        // write, early readback, second write refused while busy
        a = 5'h10 | 5'($urandom % 16);
        d = 8'($urandom);
        xfer({CMD_WRITE, a, d});
        xfer({CMD_WRITE, a, ~d});
        chk16("early echo", {CFG_RESET, 8'h00}, r);
        waitStore();
        chkNear("wait cycles", 16'(WAIT_CYC), 16'(busyCnt), 8);
        xfer({CMD_READ, a, 8'h00});
        xfer(16'h0000);
        chk16("stored reg", {d, 8'h00}, r);
        // angle path: short filter, direction, zero reference
        wr(REG_FILT, 8'h01);
        xfer(16'h0000);
        chk16("write echo", {8'h01, 8'h00}, r);
        ph = 16'($urandom);
        tdcPhase = ph;
        angChk(ph);
        // cut frame in mode 3 still answers the read, then angle again
        xfer({CMD_READ, REG_FILT, 8'h00});
        spi_master_model_i.frame(1'b1, 16'h0000, 8, r);
        chk16("cut reg", {8'h01, 8'h00}, {r[15:8], 8'h00});
        spi_master_model_i.frame(1'b0, 16'h0000, 16, r);
        chkNear("after cut", ph & PAD, r, 16);
        wr(REG_DIR, 8'h80);
        angChk(-ph);
        wr(REG_DIR, 8'h00);
        z = 16'($urandom);
        wr(REG_ZERO_LO, z[7:0]);
        wr(REG_ZERO_HI, z[15:8]);
        angChk(ph - z);
        wrap_up();
    end
endmodule // angle_sensor_spi_port_tb_top
`default_nettype wire
